// ==== shared/cssel_pkg.sv ====
// Purpose: Constants and carriers for the clock source and start-up select block
// Assumes: 100 MHz sys_clk, APB with 32-bit data
// Notes:   Trim offset is a register index; its byte address is four times the index
`default_nettype none
package cssel_pkg;
   // Register map
   localparam logic [9:0]  CSSEL_IDX_TRIM      = 10'h066;                // Register index of trim
   localparam logic [11:0] CSSEL_ADDR_TRIM     = {CSSEL_IDX_TRIM, 2'b00}; // One word per index
   localparam logic [11:0] CSSEL_ADDR_CTRL     = 12'h100;
   localparam logic [11:0] CSSEL_ADDR_STAT     = 12'h104;
   localparam logic [11:0] CSSEL_ADDR_PRESC    = 12'h108;
   // Trim fields
   localparam int          CSSEL_TRIM_RANGE_POS = 7;
   localparam int          CSSEL_TRIM_FINE_MSB  = 6;
   // Source fuse codes
   localparam logic [3:0]  CSSEL_SRC_EXT    = 4'h0;
   localparam logic [3:0]  CSSEL_SRC_RC8M   = 4'h2;
   localparam logic [3:0]  CSSEL_SRC_RC128K = 4'h3;
   localparam logic [3:0]  CSSEL_SRC_LFXTAL_HI = 4'h6;  // 0110/0111 pair, low bit is startup select
   // Timing fuse codes
   localparam logic [1:0]  CSSEL_SUT_BOD  = 2'h0;
   localparam logic [1:0]  CSSEL_SUT_FAST = 2'h1;
   localparam logic [1:0]  CSSEL_SUT_SLOW = 2'h2;
   // Factory defaults (fuse bit 0 = programmed)
   localparam logic [3:0]  CSSEL_DEF_SRC  = 4'h2;
   localparam logic [1:0]  CSSEL_DEF_SUT  = 2'h2;
   localparam logic        CSSEL_DEF_DIV8_PROG = 1'b1;
   // Prescaler reset values
   localparam logic [3:0]  CSSEL_PS_DIV8 = 4'h3;
   localparam logic [3:0]  CSSEL_PS_DIV1 = 4'h0;
   // Cycle counts of the selected source
   localparam logic [15:0] CSSEL_WAKE_6   = 16'h0006;
   localparam logic [15:0] CSSEL_WAKE_1K  = 16'h0400;
   localparam logic [15:0] CSSEL_WAKE_32K = 16'h8000;
   localparam logic [15:0] CSSEL_RST_14   = 16'h000e;
   // Millisecond extensions timed on the watchdog oscillator (ms in tenths)
   localparam int          CSSEL_T_4P1_MS_X10 = 41;
   localparam int          CSSEL_T_65_MS_X10  = 650;
   localparam int          CSSEL_T_4_MS_X10   = 40;
   localparam int          CSSEL_T_64_MS_X10  = 640;
   localparam int          CSSEL_WDT_KHZ      = 128;
   localparam int          CSSEL_WDT_4P1 = (CSSEL_T_4P1_MS_X10 * CSSEL_WDT_KHZ) / 10;
   localparam int          CSSEL_WDT_65  = (CSSEL_T_65_MS_X10 * CSSEL_WDT_KHZ) / 10;
   localparam int          CSSEL_WDT_4   = (CSSEL_T_4_MS_X10 * CSSEL_WDT_KHZ) / 10;
   localparam int          CSSEL_WDT_64  = (CSSEL_T_64_MS_X10 * CSSEL_WDT_KHZ) / 10;

   typedef enum logic [4:0] {
      CSSEL_ST_IDLE = 5'b00001,
      CSSEL_ST_WAKE = 5'b00010,
      CSSEL_ST_RCYC = 5'b00100,
      CSSEL_ST_RMS  = 5'b01000,
      CSSEL_ST_RUN  = 5'b10000
   } cssel_state_e;

   typedef struct packed {
      logic [3:0] clock_source_fuses;
      logic [1:0] startup_timing_fuses;
      logic       divide_by_eight_fuse;   // 0 = programmed
      logic       reset_pin_disable_fuse; // 0 = programmed
   } cssel_fuse_s;

   typedef struct packed {
      logic [2:0] sel;    // one-hot: ext, rc 8 MHz, rc 128 kHz in bit order; lf crystal is the separate lfxtal bit
      logic       lfxtal;
   } cssel_dummy_s;
endpackage
`default_nettype wire

// ==== core/cssel_edge_sync.sv ====
// Purpose: Two-stage synchroniser with rising-edge pulse for a foreign clock
// Assumes: src toggles far slower than sys_clk
// Notes:   First stage is read only by the second
`default_nettype none
module cssel_edge_sync (
   input  wire logic sys_clk, // System clock
   input  wire logic rst_n,   // Async reset, active low
   input  wire logic clk_en,  // Clock enable
   input  wire logic src,     // Foreign clock level
   output logic      rise     // One pulse per source rising edge
);
   logic [2:0] sh;
   // Two flops then one for edge detect
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh <= 3'h0;
      end else if (clk_en) begin
         sh <= {sh[1:0], src};
      end
   end
   assign rise = clk_en & sh[1] & ~sh[2];
endmodule
`default_nettype wire

// ==== core/cssel_top.sv ====
// Purpose: Clock source selection, start-up delay sequencing and RC trim register
// Assumes: Source clocks and watchdog oscillator arrive as slow levels sampled on sys_clk
// Notes:   Reserved fuse codes fall back to the 8 MHz RC source; no behaviour is promised
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
// Operation
// - LF crystal, select 0: 1K wake, 14 plus ms
// - LF crystal, select 1: 32K wake delay
// - Source code 0010 selects 8 MHz RC
// - Factory default RC, div8, slow timing
// - Reset loads factory calibration into trim
// - RC source: 6 wake, 14 plus ms
// - Reset pin disabled lengthens brownout delay except for LF crystal and external
// - Watchdog oscillator times reset extension always
// - Trim register at 0x66, immediate effect
// - Trim bit 7 selects overlapping range
// - Fine bits tune monotonically within range
// - Source code 0011 selects 128 kHz
// - 128 kHz: 6 wake, 14 plus 4/64 ms
// - Source code 0000 selects external pin
// - External: 6 wake, 14 plus ms
// - Div8 fuse sets prescaler reset value
module cssel_top
   import cssel_pkg::*;
#(
   parameter logic [7:0] FACTORY_TRIM = 8'h80,        // Arbitrary neutral calibration byte
   parameter int         WDT_4P1      = cssel_pkg::CSSEL_WDT_4P1,
   parameter int         WDT_65       = cssel_pkg::CSSEL_WDT_65,
   parameter int         WDT_4        = cssel_pkg::CSSEL_WDT_4,
   parameter int         WDT_64       = cssel_pkg::CSSEL_WDT_64
) (
   input  wire logic                  sys_clk,             // 100 MHz system clock
   input  wire logic                  rst_n,               // Async reset, active low
   input  wire logic                  clk_en,              // Freezes all state when low
   input  wire cssel_pkg::cssel_fuse_s fuses,              // Fuse bits, static
   input  wire logic                  oscillator_input_pin,// External clock level
   input  wire logic                  lfxtal_clk,          // Watch crystal oscillator level
   input  wire logic                  rc8m_clk,            // RC oscillator level
   input  wire logic                  rc128k_clk,          // 128 kHz oscillator level
   input  wire logic                  wdt_osc_clk,         // Watchdog oscillator level
   input  wire logic                  wake_req,            // Leave deep sleep, same domain
   input  wire logic                  psel,                // APB select
   input  wire logic                  penable,             // APB enable
   input  wire logic                  pwrite,              // APB direction
   input  wire logic [11:0]           paddr,               // APB byte address
   input  wire logic [31:0]           pwdata,              // APB write data
   output logic                       pready,              // APB ready
   output logic [31:0]                prdata,              // APB read data
   output logic                       pslverr,             // APB error
   output logic [3:0]                 src_sel,             // One-hot: ext, rc8m, rc128k, lfxtal
   output logic [7:0]                 rc_osc_trim,         // Trim to RC oscillator
   output logic [3:0]                 prescaler_select_field, // Prescaler setting
   output logic                       clk_ready,           // Internal clock released
   output logic                       core_rst_n           // Internal reset, active low
);
   import cssel_pkg::*;

   typedef struct packed {
      cssel_state_e st;
      logic [15:0]  cnt;
      logic [15:0]  ms_cnt;
      logic [15:0]  ms_goal;
      logic [7:0]   trim;
      logic [3:0]   presc;
      logic [3:0]   sel;
      logic         ready;
      logic         rstn;
      logic         pready;
      logic [31:0]  prdata;
      logic         pslverr;
      logic         wake_pend;
      logic         woke;
   } cssel_state_s;

   cssel_state_s r;
   cssel_state_s next_r;

   logic [3:0] src_rise;
   logic       wdt_rise;
   logic       src_tick;
   logic       lfx;
   logic       rst_path;
   logic [15:0] wake_cyc;
   logic [15:0] ms_sel;
   logic        acc;
   logic        wr;
   logic        hit_trim;
   logic        hit_ctrl;
   logic        hit_stat;
   logic        hit_presc;

   // One synchroniser per source clock plus the watchdog oscillator
   logic [4:0] raw_clk;
   logic [4:0] raw_rise;
   assign raw_clk = {wdt_osc_clk, lfxtal_clk, rc128k_clk, rc8m_clk, oscillator_input_pin};
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         cssel_edge_sync u_sync (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .clk_en  (clk_en),
            .src     (raw_clk[gi]),
            .rise    (raw_rise[gi])
         );
      end
   endgenerate
   assign src_rise = raw_rise[3:0];
   assign wdt_rise = raw_rise[4];

   // Source decode from fuse code
   assign lfx = (fuses.clock_source_fuses[3:1] == CSSEL_SRC_LFXTAL_HI[3:1]);
   always_comb begin
      next_r = r;
      next_r.sel = 4'h0;
      unique case (1'b1)
         (fuses.clock_source_fuses == CSSEL_SRC_EXT):    next_r.sel = 4'b0001;
         (fuses.clock_source_fuses == CSSEL_SRC_RC8M):   next_r.sel = 4'b0010;
         (fuses.clock_source_fuses == CSSEL_SRC_RC128K): next_r.sel = 4'b0100;
         lfx:                                            next_r.sel = 4'b1000;
         default:                                        next_r.sel = 4'b0010;
      endcase

      // Tick of the selected source, wake counts in its own cycles
      src_tick = |(next_r.sel & src_rise);
      wake_cyc = CSSEL_WAKE_6;
      if (lfx) begin
         wake_cyc = fuses.clock_source_fuses[0] ? CSSEL_WAKE_32K : CSSEL_WAKE_1K;
      end

      // Millisecond extension picked by timing code
      ms_sel = 16'h0;
      unique case (fuses.startup_timing_fuses)
         CSSEL_SUT_BOD:  begin
            // Reset pin disabled: keep a window for programming entry
            if (!fuses.reset_pin_disable_fuse && !lfx && fuses.clock_source_fuses != CSSEL_SRC_EXT) begin
               ms_sel = 16'(WDT_4P1);
            end
         end
         CSSEL_SUT_FAST: ms_sel = (next_r.sel[2]) ? 16'(WDT_4)  : 16'(WDT_4P1);
         CSSEL_SUT_SLOW: ms_sel = (next_r.sel[2]) ? 16'(WDT_64) : 16'(WDT_65);
         default:        ms_sel = 16'h0;
      endcase

      // Sequencer
      rst_path = 1'b0;
      unique case (r.st)
         CSSEL_ST_IDLE: begin
            // First edge after reset: calibration byte and prescaler reset value
            next_r.trim = FACTORY_TRIM;
            next_r.presc = fuses.divide_by_eight_fuse ? CSSEL_PS_DIV1 : CSSEL_PS_DIV8;
            next_r.st = CSSEL_ST_RCYC;
            next_r.cnt = 16'h0;
            next_r.ms_goal = ms_sel;
            next_r.ready = 1'b0;
            next_r.rstn = 1'b0;
         end
         CSSEL_ST_WAKE: begin
            if (src_tick) begin
               next_r.cnt = r.cnt + 16'h1;
               if (r.cnt + 16'h1 >= wake_cyc) begin
                  next_r.st = CSSEL_ST_RUN;
                  next_r.ready = 1'b1;
               end
            end
         end
         CSSEL_ST_RCYC: begin
            if (src_tick) begin
               next_r.cnt = r.cnt + 16'h1;
               if (r.cnt + 16'h1 >= CSSEL_RST_14) begin
                  next_r.st = CSSEL_ST_RMS;
                  next_r.ms_cnt = 16'h0;
               end
            end
         end
         CSSEL_ST_RMS: begin
            rst_path = 1'b1;
            if (r.ms_cnt >= r.ms_goal) begin
               next_r.st = CSSEL_ST_RUN;
               next_r.ready = 1'b1;
               next_r.rstn = 1'b1;
            end else if (wdt_rise) begin
               next_r.ms_cnt = r.ms_cnt + 16'h1;
            end
         end
         CSSEL_ST_RUN: begin
            // Sleep exit restarts only the wake count, not reset
            if (wake_req) begin
               next_r.st = CSSEL_ST_WAKE;
               next_r.cnt = 16'h0;
               next_r.ready = 1'b0;
            end
         end
         default: next_r.st = CSSEL_ST_IDLE;
      endcase

      // APB slave, zero wait states: answer in the access cycle
      acc = psel & penable;
      wr = acc & pwrite;
      hit_trim = (paddr[11:2] == CSSEL_ADDR_TRIM[11:2]);
      hit_ctrl = (paddr[11:2] == CSSEL_ADDR_CTRL[11:2]);
      hit_stat = (paddr[11:2] == CSSEL_ADDR_STAT[11:2]);
      hit_presc = (paddr[11:2] == CSSEL_ADDR_PRESC[11:2]);
      next_r.pready = psel & ~penable & (r.st != CSSEL_ST_IDLE); // Bus answers from the second edge
      next_r.pslverr = 1'b0;
      if (psel & ~penable) begin
         next_r.prdata = 32'h0;
         if (!pwrite) begin
            if (hit_trim) begin
               next_r.prdata = {24'h0, r.trim};
            end else if (hit_ctrl) begin
               next_r.prdata = {24'h0, fuses};
            end else if (hit_stat) begin
               next_r.prdata = {24'h0, r.sel, r.st[4], r.ready, r.rstn, rst_path};
            end else if (hit_presc) begin
               next_r.prdata = {28'h0, r.presc};
            end
         end
         next_r.pslverr = ~(hit_trim | hit_ctrl | hit_stat | hit_presc) | (pwrite & (hit_ctrl | hit_stat));
      end
      if (wr & r.pready & hit_trim) begin
         next_r.trim = pwdata[7:0];
      end
      if (wr & r.pready & hit_presc) begin
         next_r.presc = pwdata[3:0];
      end
   end

   // State register; clock enable low holds every field
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= CSSEL_ST_IDLE;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;
   assign src_sel = r.sel;
   assign rc_osc_trim = r.trim;
   assign prescaler_select_field = r.presc;
   assign clk_ready = r.ready;
   assign core_rst_n = r.rstn;
endmodule
`default_nettype wire

// ==== sim/cssel_top_properties.sv ====
// Purpose: Port-level timing and register checks for cssel_top
// Assumes: clk_en high while sequences run; fuses change only in reset
// Notes:   Bound to every cssel_top instance
`default_nettype none
module cssel_top_properties #(
   parameter logic [7:0] FACTORY_TRIM = 8'h80 // Arbitrary neutral byte
) (
   input wire logic                   sys_clk,     // Clock
   input wire logic                   rst_n,       // Reset, active low
   input wire logic                   clk_en,      // Enable
   input wire cssel_pkg::cssel_fuse_s fuses,       // Fuses
   input wire logic                   wake_req,    // Wake
   input wire logic                   psel,        // APB
   input wire logic                   penable,     // APB
   input wire logic                   pwrite,      // APB
   input wire logic [11:0]            paddr,       // APB
   input wire logic [31:0]            pwdata,      // APB
   input wire logic                   pready,      // APB
   input wire logic                   pslverr,     // APB
   input wire logic [3:0]             src_sel,     // Source
   input wire logic [7:0]             rc_osc_trim, // Trim
   input wire logic [3:0]             prescaler_select_field, // Prescaler
   input wire logic                   clk_ready,   // Released
   input wire logic                   core_rst_n   // Core reset
);
   timeunit 1ns;
   timeprecision 1ps;
   import cssel_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Taken APB access
   wire logic acc = psel && penable && pready && clk_en;
   wire logic [3:0] src = fuses.clock_source_fuses;
   a_sel_rc: assert property (clk_ready && src == CSSEL_SRC_RC8M |-> src_sel == 4'h2)
      else $error("rc source not selected");
   a_sel_slow: assert property (clk_ready && src == CSSEL_SRC_RC128K |-> src_sel == 4'h4)
      else $error("128k source not selected");
   a_sel_ext: assert property (clk_ready && src == CSSEL_SRC_EXT |-> src_sel == 4'h1)
      else $error("external source not selected");
   a_trim_write: assert property (acc && pwrite && paddr == CSSEL_ADDR_TRIM |=>
      rc_osc_trim == $past(pwdata[7:0])) else $error("trim write lost");
   a_trim_factory: assert property ($rose(rst_n) && clk_en |-> ##1 rc_osc_trim == FACTORY_TRIM)
      else $error("factory trim not loaded");
   a_psc_reset: assert property ($rose(rst_n) && clk_en |->
      ##1 prescaler_select_field == (fuses.divide_by_eight_fuse ? 4'h0 : 4'h3)) else $error("prescaler reset");
   a_apb_answer: assert property (psel && !penable && clk_en |=> pready ##1 !pready)
      else $error("pready timing");
   a_ro_refused: assert property (acc && pwrite && paddr == CSSEL_ADDR_STAT |-> pslverr)
      else $error("status write accepted");
   a_boot_hold: assert property ($rose(rst_n) |-> !core_rst_n [*8])
      else $error("core reset released early");
   a_release_pair: assert property ($rose(core_rst_n) |-> clk_ready)
      else $error("reset released without clock");
   a_wake_stop: assert property (clk_ready && core_rst_n && wake_req && clk_en |-> ##[1:3] !clk_ready)
      else $error("wake did not stop clock");
   c_boot: cover property ($rose(core_rst_n));
   c_wake: cover property ($fell(clk_ready) && core_rst_n);
   c_err: cover property (acc && pslverr);
endmodule
bind cssel_top cssel_top_properties #(.FACTORY_TRIM(FACTORY_TRIM)) u_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .fuses(fuses), .wake_req(wake_req),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .src_sel(src_sel), .rc_osc_trim(rc_osc_trim),
   .prescaler_select_field(prescaler_select_field), .clk_ready(clk_ready), .core_rst_n(core_rst_n));
`default_nettype wire

// ==== sim/cssel_clk_src_model.sv ====
// Purpose: Oscillator and external clock sources seen by cssel_top
// Assumes: Sources far slower than sys_clk
// Notes:   Restarted by reset so the phase at release is known
`default_nettype none
module cssel_clk_src_model (
   input  wire logic sys_clk, // Clock
   input  wire logic rst_n,   // Reset, active low
   output logic      src_clk, // Source clock, period 4
   output logic      wdt_clk  // Watchdog oscillator, period 32
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt;
   // Shared divider; known phase lets the bench predict release times
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 5'h00;
      end else begin
         cnt <= cnt + 5'h01;
      end
   end
   // Steady rate, no jump from one cycle to the next
   assign src_clk = cnt[1];
   assign wdt_clk = cnt[4];
endmodule
`default_nettype wire

// ==== sim/cssel_tb_top.sv ====
// Purpose: Self-checking bench for cssel_top
// Assumes: Watchdog goals shortened to 2..5 edges
// Notes:   Release windows allow for synchroniser delay
`default_nettype none
module cssel_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cssel_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0, wake_req = 1'b0, clk_en = 1'b1;
   localparam logic [7:0] TRIM_CAL = 8'h5a; // Arbitrary calibration byte
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, clk_ready, core_rst_n, src_clk, wdt_clk;
   logic [3:0]  src_sel, prescaler_select_field;
   logic [7:0]  rc_osc_trim;
   cssel_fuse_s fuses = 8'h25;
   int          n_errors = 0, n_compared = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   cssel_clk_src_model model (.sys_clk(sys_clk), .rst_n(rst_n), .src_clk(src_clk), .wdt_clk(wdt_clk));
   cssel_top #(.FACTORY_TRIM(TRIM_CAL), .WDT_4P1(2), .WDT_65(3), .WDT_4(4), .WDT_64(5)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .fuses(fuses), .oscillator_input_pin(src_clk),
      .lfxtal_clk(src_clk), .rc8m_clk(src_clk), .rc128k_clk(src_clk), .wdt_osc_clk(wdt_clk),
      .wake_req(wake_req), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .src_sel(src_sel),
      .rc_osc_trim(rc_osc_trim), .prescaler_select_field(prescaler_select_field),
      .clk_ready(clk_ready), .core_rst_n(core_rst_n));
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard, well above the 1K wake count the bench runs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors = n_errors + 1;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Only the bench timeout ends this wait
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge sys_clk);
   endtask
   // Source edges at 4k-2, watchdog edges at 32k-16 after release
   task automatic boot(input cssel_fuse_s f, input logic [3:0] sel, input int g);
      int t;
      t = 0;
      @(posedge sys_clk);
      fuses <= f;
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      while (core_rst_n !== 1'b1 && t < 1000) begin
         @(posedge sys_clk);
         t++;
      end
      chk(32'(t >= 32 * g + 40 && t <= 32 * g + 70), 32'h1);
      chk({28'h0, src_sel}, {28'h0, sel});
      chk({24'h0, rc_osc_trim}, {24'h0, TRIM_CAL});
      chk({28'h0, prescaler_select_field}, f.divide_by_eight_fuse ? 32'h0 : 32'h3);
   endtask
   // Clock stopped for n source edges after a wake request
   task automatic wake(input int n);
      int t;
      t = 0;
      wake_req <= 1'b1;
      @(posedge sys_clk);
      wake_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      while (clk_ready !== 1'b1 && t < 9000) begin
         @(posedge sys_clk);
         t++;
      end
      chk(32'(t >= 4 * n - 8 && t <= 4 * n + 12), 32'h1);
   endtask
   task automatic t_rc();
      boot({4'h2, 2'h2, 1'b0, 1'b1}, 4'h2, 3);
      boot({4'h2, 2'h1, 1'b1, 1'b1}, 4'h2, 2);
      boot({4'h2, 2'h0, 1'b0, 1'b1}, 4'h2, 0);
      boot({4'h2, 2'h0, 1'b0, 1'b0}, 4'h2, 2);
      wake(6);
      $display("t_rc done");
   endtask
   task automatic t_apb();
      logic [31:0] r;
      logic        e;
      apb(1'b1, CSSEL_ADDR_TRIM, 32'h7f, r, e);
      chk({24'h0, rc_osc_trim}, 32'h7f);
      chk({31'h0, e}, 32'h0);
      apb(1'b0, CSSEL_ADDR_TRIM, 32'h0, r, e);
      chk(r, 32'h7f);
      apb(1'b1, CSSEL_ADDR_TRIM, 32'h80, r, e);
      chk({24'h0, rc_osc_trim}, 32'h80);
      apb(1'b1, CSSEL_ADDR_STAT, 32'hff, r, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'h200, 32'h0, r, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, CSSEL_ADDR_PRESC, 32'h1, r, e);
      chk({28'h0, prescaler_select_field}, 32'h1);
      apb(1'b0, CSSEL_ADDR_PRESC, 32'h0, r, e);
      chk(r, 32'h1);
      apb(1'b0, CSSEL_ADDR_CTRL, 32'h0, r, e);
      chk(r, {24'h0, fuses});
      $display("t_apb done");
   endtask
   // Clock enable low must freeze the sequencer against a wake request
   task automatic t_hold();
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wake_req <= 1'b1;
      repeat (4) @(posedge sys_clk);
      clk_en <= 1'b1;
      wake_req <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, clk_ready}, 32'h1);
      $display("t_hold done");
   endtask
   task automatic t_slow();
      boot({4'h3, 2'h1, 1'b0, 1'b1}, 4'h4, 4);
      boot({4'h3, 2'h2, 1'b0, 1'b1}, 4'h4, 5);
      boot({4'h3, 2'h0, 1'b0, 1'b0}, 4'h4, 2);
      wake(6);
      $display("t_slow done");
   endtask
   task automatic t_ext();
      boot({4'h0, 2'h1, 1'b1, 1'b1}, 4'h1, 2);
      boot({4'h0, 2'h2, 1'b1, 1'b1}, 4'h1, 3);
      boot({4'h0, 2'h0, 1'b1, 1'b0}, 4'h1, 0);
      wake(6);
      $display("t_ext done");
   endtask
   task automatic t_lf();
      boot({4'h7, 2'h0, 1'b1, 1'b1}, 4'h8, 0);
      boot({4'h6, 2'h1, 1'b1, 1'b1}, 4'h8, 2);
      wake(1024);
      $display("t_lf done");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      t_rc();
      t_apb();
      t_hold();
      t_slow();
      t_ext();
      t_lf();
      stop_test();
   end
endmodule
`default_nettype wire
